// >>> rtl/mss_map.svh
// Constants for the measurement scan scheduler: codes, limits, reset values.
// Assumes inclusion by the package, the scheduler and its checker; definitions only.
`ifndef MSS_MAP_SVH
`define MSS_MAP_SVH
`define MSS_MODE_NORMAL 2'h0
`define MSS_MODE_MONITOR 2'h1
`define MSS_MODE_FAILSAFE 2'h2
`define MSS_MODE_SLEEP 2'h3
`define MSS_STOP_MANUAL 2'h0
`define MSS_STOP_TIME 2'h1
`define MSS_STOP_PERIOD 2'h2
`define MSS_SLEEP_MIN_CYC 17'h00078
`define MSS_DEF_CYCLE 17'h0003C
`define MSS_DEF_SETTLE 8'h02
`define MSS_COMMENT_MAX 7'h40
`define MSS_SEC_PER_MIN 41'h0000000003C
`define MSS_MIN_PER_HOUR 41'h0000000003C
`define MSS_MIN_PER_DAY 41'h000000005A0
`define MSS_FLASH_BIT 24
`define MSS_CLK_HZ 50000000
`endif

// >>> rtl/mss_pkg.sv
// Types shared by the scan scheduler.
// Assumes mss_map.svh is on the include path.
package mss_pkg;
`include "mss_map.svh"
    typedef enum logic [1:0] {MSS_IDLE, MSS_RUN, MSS_SETTLE, MSS_ASLEEP} mss_state_type;
    typedef struct packed {
        mss_state_type st;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [25:0] tick_cnt;
        logic [16:0] cyc_cnt;
        logic [16:0] rem;
        logic [7:0] settle_cnt;
        logic [1:0] mode;
        logic [16:0] out_cycle;
        logic save_out;
        logic save_scan;
        logic iface_out;
        logic start_timed;
        logic [1:0] stop_mode;
        logic [16:0] start_tod;
        logic [16:0] stop_tod;
        logic [16:0] period;
        logic [7:0] settle;
        logic clear_en;
        logic ring_en;
        logic [63:0][7:0] comment;
        logic [6:0] comment_len;
        logic del_pend;
        logic [25:0] flash_cnt;
        logic running;
        logic scan;
        logic to_iface;
        logic to_mem;
        logic start_ind;
        logic rec_ind;
        logic out_ind;
        logic power_on;
        logic sleep_led;
        logic clear_stats;
        logic erase_all;
        logic overwrite;
        logic cfg_reject;
        logic detect_en;
        logic [4:0] rem_h;
        logic [5:0] rem_m;
        logic [5:0] rem_s;
        logic [15:0] free_d;
        logic [4:0] free_h;
        logic [5:0] free_m;
    } mss_regs_type;
endpackage

// >>> rtl/mss_scheduler.sv
// Scan scheduler: modes, cycle timer, start/stop control, sleep cycling, memory control.
// Assumes configuration ports come from logic on clk; key and host pins are asynchronous.
`timescale 1ns/100ps
`include "mss_map.svh"
module mss_scheduler import mss_pkg::*; #(
    parameter int TICKS_PER_SEC = `MSS_CLK_HZ
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic host_scan,
    input wire logic manual_key,
    input wire logic start_key,
    input wire logic stop_key,
    input wire logic delete_key,
    input wire logic confirm_key,
    input wire logic cancel_key,
    input wire logic mem_full,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_mode,
    input wire logic [16:0] cfg_out_cycle,
    input wire logic cfg_save_out,
    input wire logic cfg_save_scan,
    input wire logic cfg_iface_out,
    input wire logic cfg_start_timed,
    input wire logic [1:0] cfg_stop_mode,
    input wire logic [16:0] cfg_start_tod,
    input wire logic [16:0] cfg_stop_tod,
    input wire logic [16:0] cfg_period,
    input wire logic [7:0] cfg_settle,
    input wire logic cfg_clear_en,
    input wire logic cfg_ring_en,
    input wire logic mem_internal,
    input wire logic comment_wr,
    input wire logic [5:0] comment_idx,
    input wire logic [7:0] comment_char,
    input wire logic [16:0] rtc_tod,
    input wire logic rtc_date_ok,
    input wire logic [23:0] mem_free_records,
    output logic running,
    output logic scan_pulse,
    output logic scan_to_iface,
    output logic scan_to_mem,
    output logic start_indicator,
    output logic recording_indicator,
    output logic output_indicator,
    output logic power_on,
    output logic sleep_indicator,
    output logic clear_stats,
    output logic erase_all,
    output logic overwrite_oldest,
    output logic sensor_detect_en,
    output logic cfg_rejected,
    output logic [4:0] remain_hours,
    output logic [5:0] remain_minutes,
    output logic [5:0] remain_seconds,
    output logic [15:0] free_days,
    output logic [4:0] free_hours,
    output logic [5:0] free_minutes,
    output logic [6:0] comment_length,
    output logic [63:0][7:0] comment_text
);
    mss_regs_type r_q, r_d;
    logic [7:0] pins, rise;
    logic tick, cyc_exp, host, man, stkey, spkey;
    logic start_now, stop_now, int_scan, host_ok;
    logic eff_save_out, eff_save_scan, eff_iface;
    logic [16:0] eff_cycle;
    logic [40:0] free_min;

    // Splits seconds into hours, minutes, seconds.
    function automatic logic [16:0] split_hms(input logic [16:0] s);
        logic [16:0] m;
        m = s / 17'(`MSS_SEC_PER_MIN);
        split_hms = {5'(m / 17'(`MSS_MIN_PER_HOUR)), 6'(m % 17'(`MSS_MIN_PER_HOUR)),
                     6'(s % 17'(`MSS_SEC_PER_MIN))};
    endfunction

    assign pins = {1'b0, cancel_key, confirm_key, delete_key, stop_key, start_key,
                   manual_key, host_scan};
    // Only the second and third flops feed logic
    assign rise = r_q.s2 & ~r_q.s3;
    assign host = rise[0];
    assign man = rise[1];
    assign stkey = rise[2];
    assign spkey = rise[3];
    assign tick = (r_q.tick_cnt == 26'(TICKS_PER_SEC - 1));

    always_comb begin
        // Sleep overrides the programmed storage and output choices
        eff_save_out = (r_q.mode == `MSS_MODE_SLEEP) ? 1'b1 : r_q.save_out;
        eff_save_scan = (r_q.mode == `MSS_MODE_SLEEP) ? 1'b0 : r_q.save_scan;
        eff_iface = (r_q.mode == `MSS_MODE_SLEEP) ? 1'b0 : r_q.iface_out;
        eff_cycle = r_q.out_cycle;
        if (r_q.mode == `MSS_MODE_SLEEP && r_q.out_cycle < `MSS_SLEEP_MIN_CYC) begin
            eff_cycle = `MSS_SLEEP_MIN_CYC;
        end
    end

    assign cyc_exp = tick && (r_q.cyc_cnt >= eff_cycle - 17'h00001);
    // Daily window when no date is set: rtc_date_ok stays high
    assign start_now = !r_q.running && (stkey ||
        (r_q.start_timed && tick && rtc_date_ok && rtc_tod == r_q.start_tod));
    assign stop_now = r_q.running && (spkey ||
        (r_q.stop_mode == `MSS_STOP_TIME && tick && rtc_tod == r_q.stop_tod) ||
        (r_q.stop_mode == `MSS_STOP_PERIOD && tick && r_q.rem <= 17'h00001));
    // Host scans have no meaning while the device is powered down
    assign host_ok = host && r_q.mode != `MSS_MODE_SLEEP;
    assign int_scan = r_q.running && cyc_exp && r_q.st == MSS_RUN &&
                      r_q.mode != `MSS_MODE_SLEEP;
    assign free_min = (41'(mem_free_records) * 41'(eff_cycle)) / `MSS_SEC_PER_MIN;

    always_comb begin
        r_d = r_q;
        r_d.s1 = pins;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        r_d.tick_cnt = tick ? 26'h0000000 : r_q.tick_cnt + 26'h0000001;
        r_d.scan = 1'b0;
        r_d.to_iface = 1'b0;
        r_d.to_mem = 1'b0;
        r_d.start_ind = 1'b0;
        r_d.rec_ind = 1'b0;
        r_d.out_ind = 1'b0;
        r_d.clear_stats = 1'b0;
        r_d.erase_all = 1'b0;
        r_d.overwrite = 1'b0;
        r_d.cfg_reject = 1'b0;
        r_d.flash_cnt = r_q.flash_cnt + 26'h0000001;

        // Configuration and comment only while idle
        if (cfg_wr && r_q.running) begin
            r_d.cfg_reject = 1'b1;
        end else if (cfg_wr) begin
            r_d.mode = cfg_mode;
            r_d.out_cycle = cfg_out_cycle;
            r_d.save_out = cfg_save_out;
            r_d.save_scan = cfg_save_scan;
            r_d.iface_out = cfg_iface_out;
            r_d.start_timed = cfg_start_timed;
            r_d.stop_mode = cfg_stop_mode;
            r_d.start_tod = cfg_start_tod;
            r_d.stop_tod = cfg_stop_tod;
            r_d.period = cfg_period;
            r_d.settle = cfg_settle;
            r_d.clear_en = cfg_clear_en;
            // Ring only on internal memory
            r_d.ring_en = cfg_ring_en && mem_internal;
        end
        if (comment_wr && r_q.running) begin
            r_d.cfg_reject = 1'b1;
        end else if (comment_wr) begin
            r_d.comment[comment_idx] = comment_char;
            if (7'(comment_idx) >= r_q.comment_len) begin
                r_d.comment_len = 7'(comment_idx) + 7'h01;
            end
        end

        // Delete needs a confirm; the cancel key drops the request
        if (rise[4]) begin
            r_d.del_pend = !r_q.running;
        end else if (r_q.del_pend && rise[5]) begin
            r_d.del_pend = 1'b0;
            r_d.erase_all = 1'b1;
            r_d.comment_len = 7'h00;
        end else if (rise[6]) begin
            r_d.del_pend = 1'b0;
        end

        // Cycle timer
        if (tick) begin
            r_d.cyc_cnt = cyc_exp ? 17'h00000 : r_q.cyc_cnt + 17'h00001;
            if (r_q.running && r_q.rem != 17'h00000) begin
                r_d.rem = r_q.rem - 17'h00001;
            end
            if (r_q.st == MSS_SETTLE && r_q.settle_cnt != 8'h00) begin
                r_d.settle_cnt = r_q.settle_cnt - 8'h01;
            end
        end
        // Failsafe host scans hold off the internal cycle; monitor leaves it alone
        if (host_ok && r_q.mode == `MSS_MODE_FAILSAFE) begin
            r_d.cyc_cnt = 17'h00000;
        end

        // Scan issue
        if (host_ok) begin
            r_d.scan = 1'b1;
            r_d.to_iface = 1'b1;
            r_d.out_ind = 1'b1;
            r_d.to_mem = r_q.running && eff_save_out;
            r_d.rec_ind = r_q.running && eff_save_out;
        end else if (int_scan) begin
            r_d.scan = 1'b1;
            // Internal scans in monitor/failsafe never reach the interface
            r_d.to_iface = eff_iface && r_q.mode == `MSS_MODE_NORMAL;
            r_d.out_ind = eff_iface && r_q.mode == `MSS_MODE_NORMAL;
            r_d.to_mem = eff_save_out;
            r_d.rec_ind = eff_save_out;
        end else if (man && r_q.st != MSS_ASLEEP) begin
            // A powered-down device cannot scan; the key is ignored until wake-up
            // Single manual scan of all channels, one pulse on the start, recording and output indicators
            r_d.scan = 1'b1;
            r_d.to_iface = eff_iface;
            r_d.to_mem = eff_save_out || eff_save_scan;
            r_d.start_ind = 1'b1;
            r_d.rec_ind = 1'b1;
            r_d.out_ind = 1'b1;
        end

        // Full memory: overwrite oldest in ring mode, else recording stops
        if (r_d.to_mem && mem_full) begin
            r_d.overwrite = r_q.ring_en;
            r_d.to_mem = r_q.ring_en;
            r_d.rec_ind = r_q.ring_en;
        end

        case (r_q.st)
            MSS_IDLE: begin
                r_d.power_on = 1'b1;
                r_d.sleep_led = 1'b0;
                if (start_now) begin
                    r_d.running = 1'b1;
                    r_d.cyc_cnt = 17'h00000;
                    // Whole seconds from the start, so settle and period are never cut short
                    r_d.tick_cnt = 26'h0000000;
                    r_d.rem = r_q.period;
                    r_d.clear_stats = r_q.clear_en;
                    if (r_q.mode == `MSS_MODE_SLEEP) begin
                        r_d.st = MSS_SETTLE;
                        r_d.settle_cnt = r_q.settle;
                    end else begin
                        r_d.st = MSS_RUN;
                    end
                end
            end
            MSS_RUN: begin
                if (stop_now) begin
                    r_d.st = MSS_IDLE;
                    r_d.running = 1'b0;
                end
            end
            MSS_SETTLE: begin
                // Slow sensors settle before the one scan of this wake-up
                r_d.power_on = 1'b1;
                r_d.sleep_led = 1'b0;
                if (stop_now || spkey) begin
                    r_d.st = MSS_IDLE;
                    r_d.running = 1'b0;
                end else if (r_q.settle_cnt == 8'h00) begin
                    r_d.scan = 1'b1;
                    r_d.to_mem = !mem_full || r_q.ring_en;
                    r_d.overwrite = mem_full && r_q.ring_en;
                    r_d.rec_ind = !mem_full || r_q.ring_en;
                    r_d.st = MSS_ASLEEP;
                end
            end
            MSS_ASLEEP: begin
                // Fully off between scans; the flashing indicator confirms it
                r_d.power_on = 1'b0;
                r_d.sleep_led = r_q.flash_cnt[`MSS_FLASH_BIT];
                if (stop_now || stkey) begin
                    r_d.st = MSS_IDLE;
                    r_d.running = 1'b0;
                    r_d.power_on = 1'b1;
                end else if (cyc_exp) begin
                    r_d.st = MSS_SETTLE;
                    r_d.settle_cnt = r_q.settle;
                end
            end
            default: begin
                r_d.st = MSS_IDLE;
                r_d.running = 1'b0;
            end
        endcase

        // Operation level folded in here so the outputs leave flops
        r_d.start_ind = r_d.start_ind || r_d.running;
        r_d.detect_en = !r_d.running;
        {r_d.rem_h, r_d.rem_m, r_d.rem_s} = split_hms(r_q.rem);
        r_d.free_d = 16'(free_min / `MSS_MIN_PER_DAY);
        r_d.free_h = 5'((free_min % `MSS_MIN_PER_DAY) / `MSS_MIN_PER_HOUR);
        r_d.free_m = 6'(free_min % `MSS_MIN_PER_HOUR);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_q <= '0;
            r_q.st <= MSS_IDLE;
            r_q.out_cycle <= `MSS_DEF_CYCLE;
            r_q.save_out <= 1'b1;
            r_q.settle <= `MSS_DEF_SETTLE;
            r_q.clear_en <= 1'b1;
            r_q.power_on <= 1'b1;
            r_q.detect_en <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign running = r_q.running;
    assign scan_pulse = r_q.scan;
    assign scan_to_iface = r_q.to_iface;
    assign scan_to_mem = r_q.to_mem;
    assign start_indicator = r_q.start_ind;
    assign recording_indicator = r_q.rec_ind;
    assign output_indicator = r_q.out_ind;
    assign power_on = r_q.power_on;
    assign sleep_indicator = r_q.sleep_led;
    assign clear_stats = r_q.clear_stats;
    assign erase_all = r_q.erase_all;
    assign overwrite_oldest = r_q.overwrite;
    // New sensors are only looked for between operations
    assign sensor_detect_en = r_q.detect_en;
    assign cfg_rejected = r_q.cfg_reject;
    assign remain_hours = r_q.rem_h;
    assign remain_minutes = r_q.rem_m;
    assign remain_seconds = r_q.rem_s;
    assign free_days = r_q.free_d;
    assign free_hours = r_q.free_h;
    assign free_minutes = r_q.free_m;
    assign comment_length = r_q.comment_len;
    assign comment_text = r_q.comment;
endmodule

// >>> verif/mss_host_model.sv
// Host computer model: sends scan requests on the host pin at a fixed spacing.
// Assumes the bench clock; requests change 2 ns after the rising edge.
`timescale 1ns/100ps
module mss_host_model #(
    parameter int GAP = 10
) (
    input wire logic clk,
    input wire logic enable,
    output logic host_scan
);
    int cnt = 0;
    logic en = 1'b0;
    initial host_scan = 1'b0;
    // Spacing is kept well below the scan cycle the bench programs
    always @(posedge clk) begin
        // Enable is taken at the edge, before the bench moves it
        en = enable;
        #2;
        if (!en) begin
            cnt = 0;
            host_scan = 1'b0;
        end else begin
            cnt = (cnt + 1) % GAP;
            host_scan = (cnt < 2);
        end
    end
endmodule

// >>> verif/mss_scheduler_chk.sv
// Port-level checker for the scan scheduler, bound to its top module.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps
`include "mss_map.svh"
module mss_scheduler_chk import mss_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_mode,
    input wire logic running,
    input wire logic scan_pulse,
    input wire logic scan_to_iface,
    input wire logic scan_to_mem,
    input wire logic power_on,
    input wire logic clear_stats,
    input wire logic erase_all,
    input wire logic overwrite_oldest,
    input wire logic sensor_detect_en,
    input wire logic cfg_rejected,
    input wire logic output_indicator,
    input wire logic [6:0] comment_length
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [1:0] mode_q;
    // Mirrors the accepted mode; writes while running do not count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `MSS_MODE_NORMAL;
        end else if (cfg_wr && !running) begin
            mode_q <= cfg_mode;
        end
    end
    chk_reject_busy: assert property (cfg_wr && running |=> cfg_rejected)
        else $error("config write while running not refused");
    chk_accept_idle: assert property (cfg_wr && !running |=> !cfg_rejected)
        else $error("config write while idle refused");
    chk_detect_gate: assert property (sensor_detect_en == !running)
        else $error("sensor detection not gated by operation");
    chk_iface_pair: assert property (scan_to_iface |-> scan_pulse && output_indicator)
        else $error("interface output without a scan");
    chk_mem_pair: assert property (scan_to_mem |-> scan_pulse)
        else $error("memory write without a scan");
    chk_sleep_quiet: assert property (
        scan_pulse && mode_q == `MSS_MODE_SLEEP |-> !scan_to_iface)
        else $error("sleep scan sent to interface");
    chk_asleep_idle: assert property (!power_on |-> running && !scan_pulse)
        else $error("powered down outside an operation or scanning");
    chk_clear_start: assert property (clear_stats |-> running)
        else $error("statistics cleared outside an operation start");
    chk_ring_store: assert property (overwrite_oldest |-> scan_to_mem)
        else $error("overwrite without a stored scan");
    chk_erase_text: assert property (erase_all |-> ##[0:1] comment_length == 7'h00)
        else $error("comment kept after erase");
    cover property (cfg_rejected);
    cover property (!power_on);
    cover property (overwrite_oldest);
    cover property (erase_all);
endmodule
bind mss_scheduler mss_scheduler_chk u_mss_scheduler_chk (.clk(clk), .reset_n(reset_n),
    .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .running(running), .scan_pulse(scan_pulse),
    .scan_to_iface(scan_to_iface), .scan_to_mem(scan_to_mem), .power_on(power_on),
    .clear_stats(clear_stats), .erase_all(erase_all), .overwrite_oldest(overwrite_oldest),
    .sensor_detect_en(sensor_detect_en), .cfg_rejected(cfg_rejected),
    .output_indicator(output_indicator), .comment_length(comment_length));

// >>> verif/mss_scheduler_bench.sv
// Self-checking bench for the scan scheduler with a host scan model.
// Assumes a one-second tick of 10 clocks; inputs change 2 ns after the edge.
`timescale 1ns/100ps
module mss_scheduler_bench import mss_pkg::*;;
    logic clk = 0, reset_n = 0, host_en = 0, host_scan, cfg_wr = 0, c_timed = 0, mem_full = 0;
    logic comment_wr = 0, rtc_ok = 1, rej, clr_en = 1, mem_int = 1, sleep_ind;
    logic [5:0] keys = 0, c_idx = 0;
    logic [1:0] c_mode = 0, c_stop = 0;
    logic [16:0] c_oc = 17'h0003C, c_per = 0, c_start = 0, c_end = 0, rtc_tod = 0;
    logic [7:0] c_chr = 0;
    logic [23:0] free_rec = 24'h0005DC;
    logic running, scan_pulse, scan_to_iface, scan_to_mem, start_ind, rec_ind, out_ind, power_on;
    logic clear_stats, erase_all, overwrite_oldest, sensor_detect_en, cfg_rejected;
    logic [4:0] remain_hours, free_hours;
    logic [5:0] remain_minutes, remain_seconds, free_minutes;
    logic [15:0] free_days;
    logic [6:0] comment_length;
    logic [63:0][7:0] comment_text;
    int errors = 0, n_tests = 0, loud = 0, quiet = 0, erases = 0, n;
    always #10 clk = ~clk;
    mss_scheduler #(.TICKS_PER_SEC(10)) u_mss_scheduler (.clk(clk), .reset_n(reset_n),
        .host_scan(host_scan), .manual_key(keys[0]), .start_key(keys[1]), .stop_key(keys[2]),
        .delete_key(keys[3]), .confirm_key(keys[4]), .cancel_key(keys[5]), .mem_full(mem_full),
        .cfg_wr(cfg_wr), .cfg_mode(c_mode), .cfg_out_cycle(c_oc), .cfg_save_out(1'b1),
        .cfg_save_scan(1'b0), .cfg_iface_out(1'b1), .cfg_start_timed(c_timed),
        .cfg_stop_mode(c_stop), .cfg_start_tod(c_start), .cfg_stop_tod(c_end),
        .cfg_period(c_per), .cfg_settle(8'h02), .cfg_clear_en(clr_en), .cfg_ring_en(1'b1),
        .mem_internal(mem_int), .comment_wr(comment_wr), .comment_idx(c_idx),
        .comment_char(c_chr), .rtc_tod(rtc_tod), .rtc_date_ok(rtc_ok),
        .mem_free_records(free_rec), .running(running), .scan_pulse(scan_pulse),
        .scan_to_iface(scan_to_iface), .scan_to_mem(scan_to_mem), .start_indicator(start_ind),
        .recording_indicator(rec_ind), .output_indicator(out_ind), .power_on(power_on),
        .sleep_indicator(sleep_ind), .clear_stats(clear_stats), .erase_all(erase_all),
        .overwrite_oldest(overwrite_oldest), .sensor_detect_en(sensor_detect_en),
        .cfg_rejected(cfg_rejected), .remain_hours(remain_hours),
        .remain_minutes(remain_minutes), .remain_seconds(remain_seconds), .free_days(free_days),
        .free_hours(free_hours), .free_minutes(free_minutes),
        .comment_length(comment_length), .comment_text(comment_text));
    mss_host_model #(.GAP(10)) u_mss_host_model (.clk(clk), .enable(host_en),
        .host_scan(host_scan));
    // Sampled on the falling edge, away from the output updates
    always @(negedge clk) begin
        if (scan_pulse === 1'b1 && scan_to_iface === 1'b1) loud++;
        if (scan_pulse === 1'b1 && scan_to_iface !== 1'b1) quiet++;
        if (erase_all === 1'b1) erases++;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task step(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task press(input int k);
        keys[k] = 1'b1;
        step(2);
        keys[k] = 1'b0;
        step(1);
    endtask
    function logic sig(input int w);
        return w == 0 ? scan_pulse : w == 1 ? running : power_on;
    endfunction
    // Waits for a level on scan, running or power; n gives the cycles spent
    task wait_on(input int w, input logic v, input int lim);
        for (n = 0; n < lim && sig(w) !== v; n++) step(1);
        check("wait level", sig(w), v);
    endtask
    task cfg(input logic [1:0] m, input logic [16:0] oc, input logic [1:0] sm,
            input logic [16:0] per);
        c_mode = m;
        c_oc = oc;
        c_stop = sm;
        c_per = per;
        cfg_wr = 1'b1;
        step(1);
        rej = cfg_rejected;
        cfg_wr = 1'b0;
        step(1);
    endtask
    initial begin
        #(20 * 20000);
        check("watchdog", 0, 1);
        give_verdict();
    end
    initial begin
        step(16);
        reset_n = 1'b1;
        step(4);
        check("power_on", power_on, 1);
        check("free days", free_days, 1);
        check("free hours", {free_hours, free_minutes}, {5'h01, 6'h00});
        c_idx = 6'h3F;
        c_chr = 8'h5A;
        comment_wr = 1'b1;
        step(1);
        comment_wr = 1'b0;
        step(1);
        check("comment", {comment_length, comment_text[63]}, {7'h40, 8'h5A});
        press(0);
        wait_on(0, 1, 8);
        check("manual", {start_ind, rec_ind, out_ind, scan_to_mem}, 4'hF);
        c_timed = 1'b1;
        c_start = 17'h00064;
        c_end = 17'h00066;
        for (int d = 0; d < 2; d++) begin
            clr_en = (d == 0);
            cfg(0, 17'h0003C, 1, 0);
            rtc_tod = 17'h00064;
            wait_on(1, 1, 15);
            check("clear at start", clear_stats, clr_en);
            rtc_tod = 17'h00066;
            wait_on(1, 0, 15);
        end
        c_timed = 1'b0;
        rtc_tod = 0;
        cfg(0, 17'h0003C, 2, 17'h00E8B);
        press(1);
        wait_on(1, 1, 8);
        cfg(3, 17'h00005, 0, 0);
        check("refused", {rej, sensor_detect_en}, 2'b10);
        check("remaining", {remain_hours, remain_minutes, remain_seconds},
              {5'h01, 6'h02, 6'h03});
        press(2);
        wait_on(1, 0, 8);
        cfg(0, 17'h0003C, 2, 17'h00003);
        press(1);
        wait_on(1, 1, 8);
        wait_on(1, 0, 50);
        check("period stop", n >= 18 && n <= 32, 1);
        cfg(2, 17'h00002, 0, 0);
        press(1);
        host_en = 1'b1;
        quiet = 0;
        step(100);
        check("failsafe held", quiet, 0);
        host_en = 1'b0;
        step(40);
        check("failsafe runs", quiet > 0, 1);
        press(2);
        cfg(1, 17'h00002, 0, 0);
        press(1);
        host_en = 1'b1;
        quiet = 0;
        loud = 0;
        step(200);
        host_en = 1'b0;
        check("monitor cycle", quiet >= 9 && quiet <= 11, 1);
        check("monitor host", loud >= 15, 1);
        press(2);
        cfg(0, 17'h00002, 0, 0);
        press(1);
        loud = 0;
        step(100);
        check("normal cycle", loud >= 4 && loud <= 6, 1);
        press(2);
        cfg(3, 17'h00005, 0, 0);
        press(1);
        wait_on(0, 1, 60);
        check("settle", n >= 17, 1);
        check("sleep scan", {scan_to_iface, scan_to_mem}, 2'b01);
        check("sleep led", sleep_ind, 1'b0);
        wait_on(2, 0, 10);
        wait_on(2, 1, 1400);
        check("sleep span", n >= 1170 && n <= 1230, 1);
        press(2);
        wait_on(1, 0, 1300);
        cfg(0, 17'h0003C, 0, 0);
        mem_full = 1'b1;
        press(1);
        press(0);
        wait_on(0, 1, 8);
        check("ring", {overwrite_oldest, scan_to_mem}, 2'b11);
        press(2);
        mem_int = 1'b0;
        cfg(0, 17'h0003C, 0, 0);
        press(0);
        wait_on(0, 1, 8);
        check("ring external", {overwrite_oldest, scan_to_mem}, 2'b00);
        mem_full = 1'b0;
        step(4);
        for (int k = 4; k <= 5; k++) begin
            press(3);
            press(9 - k);
            step(4);
        end
        check("erase", {8'(erases), comment_length}, {8'h01, 7'h00});
        give_verdict();
    end
endmodule
